// ===== rdcmd_pkg.sv
// Package for the extended read command decoder: offsets, fields, codes.
// Assumes an APB master for software and a simple media/host stream around it.
// Summary of operation
// RQ1: Command code 25h starts the extended DMA read from media to host.
// RQ2: Command code 60h starts the queued first-party DMA read.
// RQ3: Extended DMA read moves sector data in 16-bit words.
// RQ4: Host sets up its slave-DMA channel before issuing the extended read; the bench's zero-count read arms it after the command.
// RQ5: Every extended read data word is qualified by the DMA request signal.
// RQ6: Extended read raises exactly one interrupt per command at its end.
// RQ7: An uncorrectable error stops either read at the failing sector.
// RQ8: Extended read count: current byte bits 7:0, previous byte bits 15:8.
// RQ9: Extended read count of zero transfers 65,536 sectors.
// RQ10: 48-bit address: current bytes low 24 bits, previous bytes high 24 bits.
// RQ11: Queued read count comes from feature current and previous bytes.
// RQ12: Host gives each queued read a unique tag in count bits 7:3.
// RQ13: Host keeps queued tags within the reported maximum queue depth.
// RQ14: Force-media flag set makes the queued read always go to media.
// RQ15: Force-media flag clear lets the queued read use cached data.
// RQ16: Priority flag set asks for service ahead of normal commands.
// RQ17: After error, address registers report failing address by high-byte select.
// RQ18: At completion clear busy, set ready, set error bits on failure.
package rdcmd_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_FEAT    = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_LBA_LO  = 8'h08;
  localparam logic [7:0] ADDR_LBA_MID = 8'h0c;
  localparam logic [7:0] ADDR_LBA_HI  = 8'h10;
  localparam logic [7:0] ADDR_DEVICE  = 8'h14;
  localparam logic [7:0] ADDR_COMMAND = 8'h18;
  localparam logic [7:0] ADDR_STATUS  = 8'h1c;
  localparam logic [7:0] ADDR_ERROR   = 8'h20;
  localparam logic [7:0] ADDR_CTRL    = 8'h24;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h2c;
  localparam logic [7:0] ADDR_INFO    = 8'h30;
  // ==========================================================
  // Command codes and field positions
  localparam logic [7:0] CMD_READ_EXT    = 8'h25;
  localparam logic [7:0] CMD_READ_QUEUED = 8'h60;
  localparam int TAG_LSB      = 3;
  localparam int FORCE_BIT    = 7;
  localparam int PRIO_BIT     = 7;
  localparam int HIGH_SEL_BIT = 7;
  // Status bits
  localparam int ST_BUSY  = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEK  = 4;
  localparam int ST_DRQ   = 3;
  localparam int ST_ERR   = 0;
  // Error cause bits
  localparam int ER_UNC   = 6;
  localparam int ER_ABORT = 2;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_W    = 2;
  // ==========================================================
  // Sizes and reset values
  localparam int WORDS_PER_SECTOR = 256;
  localparam logic [16:0] ZERO_COUNT_SECTORS = 17'h10000;
  localparam logic [7:0]  STATUS_RESET = 8'h50;
  localparam logic [7:0]  ZERO8 = 8'h00;

  typedef enum logic [1:0] {
    RDCMD_IDLE = 2'b00,
    RDCMD_XFER = 2'b01,
    RDCMD_DONE = 2'b10
  } rdcmd_state_t;
endpackage : rdcmd_pkg

// ===== rdcmd_shadow.sv
// Holds a current and previous byte pair for one command block register.
// Assumes single-cycle write strobes from the bus slave.
module rdcmd_shadow (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] cur_o,
  output logic      [7:0] prev_o
);
  import rdcmd_pkg::*;
  logic [7:0] next_cur;
  logic [7:0] next_prev;

  // Each write pushes the previous current byte into the previous slot
  always_comb begin
    next_cur  = cur_o;
    next_prev = prev_o;
    if (wr_i) begin
      next_prev = cur_o;
      next_cur  = data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cur_o  <= ZERO8;
      prev_o <= ZERO8;
    end else begin
      cur_o  <= next_cur;
      prev_o <= next_prev;
    end
  end
endmodule // rdcmd_shadow

// ===== rdcmd_irq.sv
// Sticky interrupt status with mask; a read of the status clears it.
// Assumes event pulses of one cycle and a read strobe of one cycle.
module rdcmd_irq (
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  input  wire logic [rdcmd_pkg::IRQ_W-1:0] event_i,
  input  wire logic                        rd_clear_i,
  input  wire logic                        mask_wr_i,
  input  wire logic [rdcmd_pkg::IRQ_W-1:0] mask_data_i,
  output logic      [rdcmd_pkg::IRQ_W-1:0] status_o,
  output logic      [rdcmd_pkg::IRQ_W-1:0] mask_o,
  output logic                             irq_o
);
  import rdcmd_pkg::*;
  logic [IRQ_W-1:0] next_status;
  logic [IRQ_W-1:0] next_mask;

  // A new event in the clearing cycle survives the clear
  always_comb begin
    next_status = (rd_clear_i ? '0 : status_o) | event_i;
    next_mask   = mask_wr_i ? mask_data_i : mask_o;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      status_o <= '0;
      mask_o   <= '0;
    end else begin
      status_o <= next_status;
      mask_o   <= next_mask;
    end
  end

  assign irq_o = |(status_o & mask_o);
endmodule // rdcmd_irq

// ===== rdcmd_decode.sv
// Top of the extended/queued read command decoder with APB slave.
// Assumes a media source streaming 16-bit words and a host DMA sink.
module rdcmd_decode (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Media side
  input  wire logic        media_valid_i,
  input  wire logic [15:0] media_data_i,
  input  wire logic        media_unc_i,
  input  wire logic        cache_hit_i,
  output logic             media_ready_o,
  output logic             media_force_o,
  output logic             prio_o,
  output logic [4:0]       tag_o,
  output logic [47:0]      start_lba_o,
  // Host DMA side
  output logic             dmarq_o,
  output logic [15:0]      dma_data_o,
  input  wire logic        dmack_i,
  output logic             irq_o
);
  import rdcmd_pkg::*;

  // ==========================================================
  // Bus decode
  logic setup_wr;
  logic access;
  logic wr_feat, wr_count, wr_lo, wr_mid, wr_hi, wr_dev, wr_cmd, wr_ctrl, wr_msk;
  logic rd_irq;
  logic [7:0] feat_cur, feat_prev, cnt_cur, cnt_prev;
  logic [7:0] lo_cur, lo_prev, mid_cur, mid_prev, hi_cur, hi_prev;
  logic [7:0] device_reg;
  logic [7:0] next_device;
  logic       high_byte_select;
  logic       next_high_sel;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return hit(a, ADDR_FEAT) || hit(a, ADDR_COUNT) || hit(a, ADDR_LBA_LO) ||
           hit(a, ADDR_LBA_MID) || hit(a, ADDR_LBA_HI) || hit(a, ADDR_DEVICE) ||
           hit(a, ADDR_COMMAND) || hit(a, ADDR_STATUS) || hit(a, ADDR_ERROR) ||
           hit(a, ADDR_CTRL) || hit(a, ADDR_IRQ_ST) || hit(a, ADDR_IRQ_MSK) ||
           hit(a, ADDR_INFO);
  endfunction

  // Zero-wait slave: every access completes on its first access cycle
  assign access    = psel_i && penable_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = access && !known(paddr_i);
  assign setup_wr  = access && pwrite_i;
  assign wr_feat   = setup_wr && hit(paddr_i, ADDR_FEAT);
  assign wr_count  = setup_wr && hit(paddr_i, ADDR_COUNT);
  assign wr_lo     = setup_wr && hit(paddr_i, ADDR_LBA_LO);
  assign wr_mid    = setup_wr && hit(paddr_i, ADDR_LBA_MID);
  assign wr_hi     = setup_wr && hit(paddr_i, ADDR_LBA_HI);
  assign wr_dev    = setup_wr && hit(paddr_i, ADDR_DEVICE);
  assign wr_cmd    = setup_wr && hit(paddr_i, ADDR_COMMAND);
  assign wr_ctrl   = setup_wr && hit(paddr_i, ADDR_CTRL);
  assign wr_msk    = setup_wr && hit(paddr_i, ADDR_IRQ_MSK);
  assign rd_irq    = access && !pwrite_i && hit(paddr_i, ADDR_IRQ_ST);

  rdcmd_shadow u_feat (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr_feat),
    .data_i(pwdata_i[7:0]), .cur_o(feat_cur), .prev_o(feat_prev));
  rdcmd_shadow u_count (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr_count),
    .data_i(pwdata_i[7:0]), .cur_o(cnt_cur), .prev_o(cnt_prev));
  rdcmd_shadow u_lo (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr_lo),
    .data_i(pwdata_i[7:0]), .cur_o(lo_cur), .prev_o(lo_prev));
  rdcmd_shadow u_mid (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr_mid),
    .data_i(pwdata_i[7:0]), .cur_o(mid_cur), .prev_o(mid_prev));
  rdcmd_shadow u_hi (.clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr_hi),
    .data_i(pwdata_i[7:0]), .cur_o(hi_cur), .prev_o(hi_prev));

  always_comb begin
    next_device   = wr_dev ? pwdata_i[7:0] : device_reg;
    next_high_sel = wr_ctrl ? pwdata_i[HIGH_SEL_BIT] : high_byte_select;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      device_reg       <= ZERO8;
      high_byte_select <= 1'b0;
    end else begin
      device_reg       <= next_device;
      high_byte_select <= next_high_sel;
    end
  end

  // ==========================================================
  // Command engine
  rdcmd_state_t state, next_state;
  logic [16:0] sectors_left, next_sectors_left;
  logic [7:0]  word_cnt, next_word_cnt;
  logic [47:0] cur_lba, next_cur_lba;
  logic [47:0] fail_lba, next_fail_lba;
  logic        is_ext, next_is_ext;
  logic        force_media, next_force_media;
  logic        prio, next_prio;
  logic [4:0]  tag, next_tag;
  logic [7:0]  status_reg, next_status_reg;
  logic [7:0]  error_reg, next_error_reg;
  logic [15:0] dma_data, next_dma_data;
  logic        dma_full, next_dma_full;
  logic        ev_done, ev_fail;
  logic [15:0] new_count;
  logic [47:0] new_lba;
  logic        start;
  logic        take;
  logic        irq_dummy_unused;

  assign new_lba = {hi_prev, mid_prev, lo_prev, hi_cur, mid_cur, lo_cur}; // [RQ10]
  assign start   = wr_cmd && (state != RDCMD_XFER);
  // Stage register accepts a media word when empty or being drained
  assign take    = (state == RDCMD_XFER) && media_valid_i && !media_unc_i && (!dma_full || dmack_i);

  always_comb begin
    next_state        = state;
    next_sectors_left = sectors_left;
    next_word_cnt     = word_cnt;
    next_cur_lba      = cur_lba;
    next_fail_lba     = fail_lba;
    next_is_ext       = is_ext;
    next_force_media  = force_media;
    next_prio         = prio;
    next_tag          = tag;
    next_status_reg   = status_reg;
    next_error_reg    = error_reg;
    next_dma_data     = dma_data;
    next_dma_full     = dma_full && !dmack_i;
    ev_done           = 1'b0;
    ev_fail           = 1'b0;
    new_count         = 16'h0000;
    case (state)
      RDCMD_IDLE, RDCMD_DONE: begin
        next_state = RDCMD_IDLE;
        if (start) begin
          next_cur_lba   = new_lba;
          next_error_reg = ZERO8;
          next_status_reg = (status_reg | (8'h01 << ST_BUSY)) & ~(8'h01 << ST_ERR);
          next_word_cnt  = 8'h00;
          if (pwdata_i[7:0] == CMD_READ_EXT) begin // [RQ1]
            new_count         = {cnt_prev, cnt_cur}; // [RQ8]
            next_is_ext       = 1'b1;
            next_force_media  = 1'b0;
            next_prio         = 1'b0;
            // Zero means the full 65,536-sector span
            next_sectors_left = (new_count == 16'h0000) ? ZERO_COUNT_SECTORS : {1'b0, new_count}; // [RQ9]
            next_state        = RDCMD_XFER;
          end else if (pwdata_i[7:0] == CMD_READ_QUEUED) begin // [RQ2]
            new_count         = {feat_prev, feat_cur}; // [RQ11]
            next_is_ext       = 1'b0;
            next_tag          = cnt_cur[7:TAG_LSB];
            next_force_media  = device_reg[FORCE_BIT]; // [RQ14] [RQ15]
            next_prio         = cnt_prev[PRIO_BIT]; // [RQ16]
            next_sectors_left = (new_count == 16'h0000) ? ZERO_COUNT_SECTORS : {1'b0, new_count};
            next_state        = RDCMD_XFER;
          end else begin
            // Unknown command: abort at once
            next_error_reg[ER_ABORT] = 1'b1;
            next_status_reg = (status_reg & ~(8'h01 << ST_BUSY)) | (8'h01 << ST_READY) | (8'h01 << ST_ERR);
            ev_fail = 1'b1;
          end
        end
      end
      RDCMD_XFER: begin
        if (media_valid_i && media_unc_i) begin
          // Stop at the failing sector, latch its address
          next_fail_lba            = cur_lba; // [RQ7] [RQ17]
          next_error_reg[ER_UNC]   = 1'b1; // [RQ18]
          next_status_reg = (status_reg & ~(8'h01 << ST_BUSY)) | (8'h01 << ST_READY) | (8'h01 << ST_ERR);
          next_state = RDCMD_DONE;
          ev_done    = 1'b1; // [RQ6]
          ev_fail    = 1'b1;
        end else if (take) begin
          next_dma_data = media_data_i; // [RQ3]
          next_dma_full = 1'b1;
          next_word_cnt = word_cnt + 8'h01;
          if (word_cnt == 8'(WORDS_PER_SECTOR - 1)) begin
            next_cur_lba      = cur_lba + 48'h1;
            next_sectors_left = sectors_left - 17'h1;
            if (sectors_left == 17'h1) begin
              next_status_reg = (status_reg & ~(8'h01 << ST_BUSY)) | (8'h01 << ST_READY) | (8'h01 << ST_SEEK); // [RQ18]
              next_state = RDCMD_DONE;
              ev_done    = 1'b1; // [RQ6]
            end
          end
        end
      end
      default: next_state = RDCMD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state        <= RDCMD_IDLE;
      sectors_left <= 17'h0;
      word_cnt     <= 8'h00;
      cur_lba      <= 48'h0;
      fail_lba     <= 48'h0;
      is_ext       <= 1'b0;
      force_media  <= 1'b0;
      prio         <= 1'b0;
      tag          <= 5'h00;
      status_reg   <= STATUS_RESET;
      error_reg    <= ZERO8;
      dma_data     <= 16'h0000;
      dma_full     <= 1'b0;
    end else begin
      state        <= next_state;
      sectors_left <= next_sectors_left;
      word_cnt     <= next_word_cnt;
      cur_lba      <= next_cur_lba;
      fail_lba     <= next_fail_lba;
      is_ext       <= next_is_ext;
      force_media  <= next_force_media;
      prio         <= next_prio;
      tag          <= next_tag;
      status_reg   <= next_status_reg;
      error_reg    <= next_error_reg;
      dma_data     <= next_dma_data;
      dma_full     <= next_dma_full;
    end
  end

  // Cache may serve only when the force flag is clear
  assign media_ready_o = (state == RDCMD_XFER) && (!dma_full || dmack_i);
  assign media_force_o = force_media || !cache_hit_i;
  assign prio_o        = prio;
  assign tag_o         = tag;
  assign start_lba_o   = cur_lba;
  assign dmarq_o       = dma_full; // [RQ5]
  assign dma_data_o    = dma_data;

  // ==========================================================
  // Interrupts and read-back
  logic [IRQ_W-1:0] irq_st, irq_msk, irq_ev;
  assign irq_ev = {ev_fail, ev_done} & {IRQ_W{1'b1}};
  assign irq_dummy_unused = is_ext;

  rdcmd_irq u_irq (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .event_i    (irq_ev),
    .rd_clear_i (rd_irq),
    .mask_wr_i  (wr_msk),
    .mask_data_i(pwdata_i[IRQ_W-1:0]),
    .status_o   (irq_st),
    .mask_o     (irq_msk),
    .irq_o      (irq_o)
  );

  // High-byte select picks the upper address bytes of the failing sector
  always_comb begin
    prdata_o = 32'h0;
    if (access && !pwrite_i) begin
      case (paddr_i)
        ADDR_FEAT:    prdata_o = {24'h0, feat_cur};
        ADDR_COUNT:   prdata_o = {24'h0, cnt_cur};
        ADDR_LBA_LO:  prdata_o = {24'h0, high_byte_select ? fail_lba[31:24] : fail_lba[7:0]}; // [RQ17]
        ADDR_LBA_MID: prdata_o = {24'h0, high_byte_select ? fail_lba[39:32] : fail_lba[15:8]};
        ADDR_LBA_HI:  prdata_o = {24'h0, high_byte_select ? fail_lba[47:40] : fail_lba[23:16]};
        ADDR_DEVICE:  prdata_o = {24'h0, device_reg};
        ADDR_STATUS:  prdata_o = {24'h0, status_reg[7:4], dma_full, status_reg[2:0]};
        ADDR_ERROR:   prdata_o = {24'h0, error_reg};
        ADDR_CTRL:    prdata_o = {24'h0, high_byte_select, 7'h00};
        ADDR_IRQ_ST:  prdata_o = {30'h0, irq_st};
        ADDR_IRQ_MSK: prdata_o = {30'h0, irq_msk};
        ADDR_INFO:    prdata_o = {15'h0, sectors_left};
        default:      prdata_o = 32'h0;
      endcase
    end
  end
endmodule // rdcmd_decode

// ===== rdcmd_chk.sv
// Checker for the read command decoder: APB answers, word stream, flags.
// Assumes it is bound to rdcmd_decode and sees only that module's ports.
module rdcmd_chk
  import rdcmd_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        media_valid_i,
  input wire logic [15:0] media_data_i,
  input wire logic        media_unc_i,
  input wire logic        media_ready_o,
  input wire logic        media_force_o,
  input wire logic        cache_hit_i,
  input wire logic        dmarq_o,
  input wire logic [15:0] dma_data_o,
  input wire logic        dmack_i,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // Sequences
  sequence s_access; psel_i && penable_i; endsequence
  // A failing word meets ready but is never staged
  sequence s_taken; media_valid_i && media_ready_o && !media_unc_i; endsequence
  sequence s_held; dmarq_o && !dmack_i; endsequence
  logic unmapped;
  assign unmapped = (paddr_i > ADDR_INFO) || (paddr_i[1:0] != 2'h0);
  // ==========================================================
  // Assertions
  a_pready_high: assert property (s_access |-> pready_o) else $error("pready low in access");
  a_mapped_ok: assert property (s_access ##0 !unmapped |-> !pslverr_o) else $error("error on mapped access");
  a_unmapped_err: assert property (s_access ##0 unmapped |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  a_word_to_dmarq: assert property (s_taken |=> dmarq_o && dma_data_o == $past(media_data_i))
    else $error("taken word not offered");
  a_dmarq_hold: assert property (s_held |=> dmarq_o && $stable(dma_data_o))
    else $error("offered word dropped");
  a_no_overrun: assert property (s_held |-> !(media_valid_i && media_ready_o))
    else $error("word taken over held word");
  a_no_spurious: assert property (!(media_valid_i && media_ready_o) && (!dmarq_o || dmack_i) |=> !dmarq_o)
    else $error("request without word");
  a_reset_quiet: assert property ($rose(reset_n_i) |-> !dmarq_o && !irq_o)
    else $error("outputs busy after reset");
  a_force_media: assert property (!cache_hit_i |-> media_force_o)
    else $error("cache miss not sent to media");
  a_status_drq: assert property (s_access ##0 (!pwrite_i && paddr_i == ADDR_STATUS) |-> prdata_o[ST_DRQ] == dmarq_o)
    else $error("status request bit wrong");
endmodule // rdcmd_chk

bind rdcmd_decode rdcmd_chk u_rdcmd_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .media_valid_i(media_valid_i), .media_data_i(media_data_i), .media_unc_i(media_unc_i),
  .media_ready_o(media_ready_o), .media_force_o(media_force_o), .cache_hit_i(cache_hit_i),
  .dmarq_o(dmarq_o), .dma_data_o(dma_data_o), .dmack_i(dmack_i), .irq_o(irq_o));

// ===== rdcmd_media_model.sv
// Far-side model: media word source and host DMA sink, fast or stalling.
// Assumes the bench enables it before each read command but the zero-count read, and disables it between commands.
module rdcmd_media_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        en_i,
  input  wire logic        slow_i,
  input  wire logic [31:0] unc_at_i,
  input  wire logic [15:0] base_i,
  input  wire logic        media_ready_i,
  input  wire logic        dmarq_i,
  output logic             media_valid_o,
  output logic             media_unc_o,
  output logic [15:0]      media_data_o,
  output logic             dmack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] idx  = 32'h0;
  logic        tick = 1'b0;
  // Host channel armed before the command is written in the first two reads, after it in the zero-count read
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !en_i) begin
      idx  <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      if (media_valid_o && media_ready_i) idx <= idx + 32'h1;
    end
  end
  assign media_valid_o = en_i && (!slow_i || tick);
  // Idle data shows the inverse so a stale word never looks valid
  assign media_data_o  = media_valid_o ? base_i + idx[15:0] : ~(base_i + idx[15:0] - 16'h1);
  assign media_unc_o   = media_valid_o && (idx == unc_at_i);
  assign dmack_o       = en_i && dmarq_i && (!slow_i || !tick);
endmodule // rdcmd_media_model

// ===== rdcmd_decode_tb_top.sv
// Self-checking bench for the read command decoder over APB.
// Assumes the far-side model and the bound checker compile alongside.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module rdcmd_decode_tb_top;
  import rdcmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, reset_n_i, psel, penable, pwrite, cache_hit, en, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_o, unc_at;
  logic        pready_o, pslverr_o, media_valid, media_unc, media_ready_o, media_force_o, prio_o;
  logic        dmarq_o, dmack_i, irq_o, irq_prev;
  logic [15:0] media_data, dma_data_o, base;
  logic [4:0]  tag_o;
  logic [47:0] start_lba_o, fail_lba;
  int          fail_count, n_compared, rx, irqs;
  rdcmd_decode u_rdcmd_decode (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .media_valid_i(media_valid), .media_data_i(media_data), .media_unc_i(media_unc),
    .cache_hit_i(cache_hit), .media_ready_o(media_ready_o), .media_force_o(media_force_o), .prio_o(prio_o),
    .tag_o(tag_o), .start_lba_o(start_lba_o), .dmarq_o(dmarq_o), .dma_data_o(dma_data_o),
    .dmack_i(dmack_i), .irq_o(irq_o));
  rdcmd_media_model u_rdcmd_media_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(en), .slow_i(slow),
    .unc_at_i(unc_at), .base_i(base), .media_ready_i(media_ready_o), .dmarq_i(dmarq_o),
    .media_valid_o(media_valid), .media_unc_o(media_unc), .media_data_o(media_data), .dmack_o(dmack_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ==========================================================
  // Host-side word and interrupt monitors
  always @(posedge clk_i) begin
    if (dmarq_o === 1'b1 && dmack_i === 1'b1) begin
      `CHK("dma word", base + rx[15:0], dma_data_o)
      rx++;
    end
    if (irq_o === 1'b1 && irq_prev !== 1'b1) irqs++;
    irq_prev <= irq_o;
  end
  // ==========================================================
  // Bus tasks
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 50);
    r = prdata_o;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin fail_count++; summarize(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask
  // Previous byte first, then current
  task automatic wr2(input logic [7:0] a, input logic [7:0] p, input logic [7:0] c);
    wr(a, p);
    wr(a, c);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK(nm, e, r)
  endtask
  task automatic wait_idle();
    logic [31:0] r;
    int n;
    n = 0;
    do begin apb(1'b0, ADDR_STATUS, 32'h0, r); n++; end while (r[ST_BUSY] !== 1'b0 && n < 5000);
    if (n >= 5000) begin fail_count++; summarize(); end
    @(negedge clk_i);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, en, slow, irq_prev} = 6'h00;
    {paddr, pwdata} = 40'h0;
    {fail_count, n_compared, rx, irqs} = '0;
    cache_hit = 1'b1;
    unc_at = 32'hffffffff;
    base = 16'h1000;
    reset_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd("status reset", ADDR_STATUS, 32'h50);
    rd("error reset", ADDR_ERROR, 32'h0);
    rd("unmapped read", 8'h40, 32'h0);
    wr(ADDR_COMMAND, 8'h00);
    rd("abort cause", ADDR_ERROR, 32'h04);
    rd("abort status", ADDR_STATUS, 32'h51);
    rd("abort irq", ADDR_IRQ_ST, 32'h2);
    wr(ADDR_IRQ_MSK, 8'h03);
    $display("test reset done");
    slow <= 1'b1;
    en <= 1'b1;
    wr2(ADDR_COUNT, 8'h00, 8'h02);
    wr2(ADDR_LBA_LO, 8'h56, 8'hbc);
    wr2(ADDR_LBA_MID, 8'h34, 8'h9a);
    wr2(ADDR_LBA_HI, 8'h12, 8'h78);
    wr(ADDR_COMMAND, CMD_READ_EXT);
    wait_idle();
    `CHK("ext lba", 48'h123456789abc + 48'd2, start_lba_o)
    `CHK("ext words", 2 * WORDS_PER_SECTOR, rx)
    `CHK("ext irq count", 1, irqs)
    rd("ext status", ADDR_STATUS, 32'h50);
    rd("irq status", ADDR_IRQ_ST, 32'h1);
    rd("irq cleared", ADDR_IRQ_ST, 32'h0);
    @(negedge clk_i);
    `CHK("irq low", 1'b0, irq_o)
    $display("test extended read done");
    @(posedge clk_i);
    en <= 1'b0;
    @(posedge clk_i);
    {slow, en, rx} <= {2'b01, 32'd0};
    base <= 16'h2000;
    unc_at <= 32'd266;
    wr2(ADDR_FEAT, 8'h00, 8'h03);
    wr2(ADDR_COUNT, 8'h80, 8'h28);
    wr2(ADDR_LBA_LO, 8'h0c, 8'h0f);
    wr2(ADDR_LBA_MID, 8'h0b, 8'h0e);
    wr2(ADDR_LBA_HI, 8'h0a, 8'h0d);
    wr(ADDR_DEVICE, 8'hc0);
    wr(ADDR_COMMAND, CMD_READ_QUEUED);
    wait_idle();
    `CHK("tag", 5'h05, tag_o)
    `CHK("prio", 1'b1, prio_o)
    `CHK("force", 1'b1, media_force_o)
    `CHK("stop at bad sector", 1'b1, rx >= 256 && rx <= 266)
    rd("err cause", ADDR_ERROR, 32'h40);
    rd("fail status", ADDR_STATUS, 32'h51);
    rd("irq both", ADDR_IRQ_ST, 32'h3);
    fail_lba = 48'h0a0b0c0d0e10;
    for (int h = 0; h < 2; h++) begin
      wr(ADDR_CTRL, h ? 8'h80 : 8'h00);
      for (int k = 0; k < 3; k++) rd("fail lba", ADDR_LBA_LO + 8'(4 * k), {24'h0, fail_lba[24*h+8*k +: 8]});
    end
    $display("test queued read error done");
    en <= 1'b0;
    base <= 16'h3000;
    unc_at <= 32'd0;
    wr(ADDR_IRQ_MSK, 8'h00);
    wr(ADDR_DEVICE, 8'h40);
    wr2(ADDR_COUNT, 8'h00, 8'h00);
    wr(ADDR_COMMAND, CMD_READ_EXT);
    rd("zero count sectors", ADDR_INFO, {15'h0, ZERO_COUNT_SECTORS});
    en <= 1'b1;
    wait_idle();
    `CHK("masked irq", 1'b0, irq_o)
    rd("masked status", ADDR_IRQ_ST, 32'h3);
    @(negedge clk_i);
    `CHK("cache used", 1'b0, media_force_o)
    @(posedge clk_i);
    cache_hit <= 1'b0;
    @(negedge clk_i);
    `CHK("cache miss", 1'b1, media_force_o)
    $display("test zero count done");
    summarize();
  end
endmodule // rdcmd_decode_tb_top
